//--- pkg/srp_defs.svh
// srp_defs.svh: offsets, field positions, reset values and timing counts
// assumes a 10 MHz core clock and a byte-wide serial receiver on that clock
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH
`define SRP_ADDR_CTRL   8'h00
`define SRP_ADDR_DELIM  8'h04
`define SRP_ADDR_PLEN   8'h08
`define SRP_ADDR_FLUSH  8'h0C
`define SRP_ADDR_INACT  8'h10
`define SRP_ADDR_STAT   8'h14
`define SRP_CTRL_RTS    0
`define SRP_CTRL_DTR    1
`define SRP_CTRL_DSEL   2
`define SRP_CTRL_DHIGH  3
`define SRP_CTRL_D1EN   4
`define SRP_CTRL_D2EN   5
`define SRP_CTRL_MODE   7:6
`define SRP_CTRL_RST    8'h03
`define SRP_DELIM_RST   16'h0000
`define SRP_PLEN_RST    11'h000
`define SRP_FLUSH_RST   16'h0000
`define SRP_INACT_RST   16'h0000
`define SRP_BUF_BYTES   11'h400
`define SRP_CLK_NS      100
`define SRP_MS_NS       1000000
`define SRP_TICK_CYC    (`SRP_MS_NS / `SRP_CLK_NS)
`endif

//--- pkg/srp_pkg.sv
// srp_pkg: types shared by the packetizer and its bench
// assumes srp_defs.svh sits on the include path
package srp_pkg;
  typedef enum {ST_FILL, ST_DRAIN} srp_state_e;
  typedef enum logic [1:0] {TM_PASS, TM_PLUS1, TM_PLUS2, TM_STRIP} srp_mode_e;
  // one byte towards the network, last marks the packet end
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } srp_beat_s;
endpackage : srp_pkg

//--- logic/srp_byte_ram.sv
// srp_byte_ram: 1024 x 8 packet store, one write and one read port
// assumes a single clock; read data appear one cycle after i_rd
`timescale 1ns/1ps
module srp_byte_ram (
  input  wire logic       i_core_clk, // core clock
  input  wire logic       i_wr,       // write strobe
  input  wire logic [9:0] i_waddr,    // write address
  input  wire logic [7:0] i_wdata,    // write byte
  input  wire logic       i_rd,       // read strobe
  input  wire logic [9:0] i_raddr,    // read address
  output logic      [7:0] o_rdata     // registered read byte
);
  import srp_pkg::*;
  logic [7:0] mem [0:1023];
  // no reset on the array: contents are always written before use
  always_ff @(posedge i_core_clk)
  begin
    if (i_wr)
    begin
      mem[i_waddr] <= i_wdata;
    end
    if (i_rd)
    begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : srp_byte_ram

//--- logic/srp_rx_packetizer.sv
// srp_rx_packetizer: gathers serial bytes and closes them into packets
// assumes i_rx_* and i_tx_ready come from core-clock logic, i_net_up is a
// pin and is synchronised here; the ms tick divides the core clock
// Behaviour
// - on link loss the selected modem line is driven low or high, as the level bit sets
// - length limit zero: close only on delimiter, full buffer or idle
// - length limit 1..1024: close when byte count reaches it
// - two enabled delimiters; with both they must arrive in order
// - with delimiters on, store until buffer full or sequence seen
// - handling mode ignored while first delimiter disabled
// - pass mode: close at once, delimiter bytes kept
// - plus-one mode: take one more byte, then close
// - plus-two mode: take two more bytes, then close
// - strip mode: close and drop the delimiter bytes
// - idle time zero: never close on a reception gap
// - idle time 1..65535 ms: close after that gap
// - close connection after inactivity interval with no data moved
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_rx_packetizer #(
  parameter int unsigned TICK_CYC = `SRP_TICK_CYC // cycles per ms
) (
  input  wire logic              i_core_clk,  // 10 MHz core clock
  input  wire logic              i_srst,      // sync reset, active high
  input  wire logic [7:0]        i_reg_addr,  // register byte address
  input  wire logic [31:0]       i_reg_wdata, // register write data
  input  wire logic              i_reg_wr,    // write strobe
  input  wire logic              i_reg_rd,    // read strobe
  output logic      [31:0]       o_reg_rdata, // read data, next cycle
  input  wire logic              i_rx_valid,  // serial byte offered
  input  wire logic [7:0]        i_rx_data,   // serial byte
  output logic                   o_rx_ready,  // byte taken when high
  output logic                   o_tx_valid,  // beat to network
  output srp_pkg::srp_beat_s     o_tx_beat,   // byte and last flag
  input  wire logic              i_tx_ready,  // network takes beat
  input  wire logic              i_net_up,    // connection up, async pin
  output logic                   o_net_close, // close request pulse
  output logic                   o_rts,       // modem rts line
  output logic                   o_dtr        // modem dtr line
);
  import srp_pkg::*;

  // counter step that saturates, shared by the ms timers
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat_inc

  logic [7:0]  ctrl_reg,  ctrl_next;
  logic [15:0] delim_reg, delim_next;
  logic [10:0] plen_reg,  plen_next;
  logic [15:0] flush_reg, flush_next;
  logic [15:0] inact_reg, inact_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        sync1_reg, sync2_reg;
  logic [31:0] tick_reg,  tick_next;
  logic        tick;
  srp_state_e  state_reg, state_next;
  logic [10:0] wcnt_reg,  wcnt_next;
  logic [10:0] rd_len_reg, rd_len_next;
  logic [10:0] rd_ptr_reg, rd_ptr_next;
  logic        prev_d1_reg, prev_d1_next;
  logic [1:0]  extra_reg, extra_next;
  logic [15:0] idle_reg,  idle_next;
  logic [15:0] inact_cnt_reg, inact_cnt_next;
  logic [15:0] pkts_reg,  pkts_next;
  logic        close_reg, close_next;
  logic        rts_reg, rts_next, dtr_reg, dtr_next;
  logic        infl_reg, infl_next, infl_last_reg, infl_last_next;
  srp_beat_s   fifo_reg [0:1];
  srp_beat_s   fifo_next [0:1];
  logic        fwp_reg, fwp_next, frp_reg, frp_next;
  logic [1:0]  fcnt_reg, fcnt_next;
  logic [7:0]  ram_rdata;
  logic        acc, match, term_hit, len_hit, full_hit, idle_hit;
  logic        plus_done, close, net_up, pop, rd_go, moved, inact_hit;
  logic [10:0] newcnt, tlen, close_len;
  srp_mode_e   mode;

  assign net_up = sync2_reg;
  assign mode   = srp_mode_e'(ctrl_reg[`SRP_CTRL_MODE]);

  // register writes and read mux; unmapped reads answer zero
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    delim_next = delim_reg;
    plen_next  = plen_reg;
    flush_next = flush_reg;
    inact_next = inact_reg;
    rdata_next = 32'h0000_0000;
    if (i_reg_wr)
    begin
      if (i_reg_addr == `SRP_ADDR_CTRL)
        ctrl_next = i_reg_wdata[7:0];
      else if (i_reg_addr == `SRP_ADDR_DELIM)
        delim_next = i_reg_wdata[15:0];
      else if (i_reg_addr == `SRP_ADDR_PLEN)
        plen_next = (i_reg_wdata[15:0] > 16'h0400) ? `SRP_BUF_BYTES
                                                   : i_reg_wdata[10:0];
      else if (i_reg_addr == `SRP_ADDR_FLUSH)
        flush_next = i_reg_wdata[15:0];
      else if (i_reg_addr == `SRP_ADDR_INACT)
        inact_next = i_reg_wdata[15:0];
    end
    if (i_reg_rd)
    begin
      if (i_reg_addr == `SRP_ADDR_CTRL)
        rdata_next = {24'h000000, ctrl_reg};
      else if (i_reg_addr == `SRP_ADDR_DELIM)
        rdata_next = {16'h0000, delim_reg};
      else if (i_reg_addr == `SRP_ADDR_PLEN)
        rdata_next = {21'h000000, plen_reg};
      else if (i_reg_addr == `SRP_ADDR_FLUSH)
        rdata_next = {16'h0000, flush_reg};
      else if (i_reg_addr == `SRP_ADDR_INACT)
        rdata_next = {16'h0000, inact_reg};
      else if (i_reg_addr == `SRP_ADDR_STAT)
        rdata_next = {pkts_reg, 2'h0, net_up, (state_reg == ST_DRAIN),
                      1'h0, wcnt_reg};
    end
  end

  // ms tick divider
  always_comb
  begin
    tick      = (tick_reg == 32'(TICK_CYC - 1));
    tick_next = tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
  end

  // receive side decode; the buffer stalls the serial side while draining
  always_comb
  begin
    o_rx_ready = (state_reg == ST_FILL);
    acc        = i_rx_valid && o_rx_ready;
    newcnt     = wcnt_reg + 11'h001;
    tlen       = ctrl_reg[`SRP_CTRL_D2EN] ? 11'h002 : 11'h001;
    match      = 1'b0;
    if (ctrl_reg[`SRP_CTRL_D1EN])
    begin
      if (ctrl_reg[`SRP_CTRL_D2EN])
        match = prev_d1_reg && (i_rx_data == delim_reg[15:8]);
      else
        match = (i_rx_data == delim_reg[7:0]);
    end
    term_hit  = acc && match && (extra_reg == 2'h0);
    len_hit   = acc && (plen_reg != 11'h000) && (newcnt == plen_reg);
    full_hit  = acc && (newcnt == `SRP_BUF_BYTES);
    plus_done = acc && (extra_reg == 2'h1);
    idle_hit  = !acc && (flush_reg != 16'h0000) && (wcnt_reg != 11'h000)
                && (idle_reg >= flush_reg) && tick;
  end

  // fill, close and drain; every close cause folds into one close
  always_comb
  begin
    state_next   = state_reg;
    wcnt_next    = wcnt_reg;
    rd_len_next  = rd_len_reg;
    rd_ptr_next  = rd_ptr_reg;
    prev_d1_next = prev_d1_reg;
    extra_next   = extra_reg;
    idle_next    = idle_reg;
    pkts_next    = pkts_reg;
    close        = 1'b0;
    close_len    = newcnt;
    if (acc)
    begin
      wcnt_next    = newcnt;
      idle_next    = 16'h0000;
      prev_d1_next = (i_rx_data == delim_reg[7:0]);
      if (extra_reg != 2'h0)
        extra_next = extra_reg - 2'h1;
      if (len_hit || full_hit || plus_done)
        close = 1'b1;
      else if (term_hit)
      begin
        if (mode == TM_PLUS1)
          extra_next = 2'h1;
        else if (mode == TM_PLUS2)
          extra_next = 2'h2;
        else
          close = 1'b1;
      end
      if (close && term_hit && (mode == TM_STRIP))
        close_len = newcnt - tlen;
    end
    else if (idle_hit)
    begin
      close     = 1'b1;
      close_len = wcnt_reg;
    end
    else if (tick && (wcnt_reg != 11'h000) && (flush_reg != 16'h0000))
      idle_next = sat_inc(idle_reg);
    if (close)
    begin
      wcnt_next    = 11'h000;
      prev_d1_next = 1'b0;
      extra_next   = 2'h0;
      idle_next    = 16'h0000;
      if (close_len != 11'h000)
      begin
        state_next  = ST_DRAIN;
        rd_len_next = close_len;
        rd_ptr_next = 11'h000;
        pkts_next   = pkts_reg + 16'h0001;
      end
    end
    if ((state_reg == ST_DRAIN) && rd_go)
      rd_ptr_next = rd_ptr_reg + 11'h001;
    if ((state_reg == ST_DRAIN) && (rd_ptr_reg == rd_len_reg) && !infl_reg
        && (fcnt_reg == 2'h0))
      state_next = ST_FILL;
  end

  // two-entry buffer towards the network; reads issue only with room
  always_comb
  begin
    o_tx_valid     = (fcnt_reg != 2'h0);
    o_tx_beat      = fifo_reg[frp_reg];
    pop            = o_tx_valid && i_tx_ready;
    rd_go          = (state_reg == ST_DRAIN) && (rd_ptr_reg != rd_len_reg)
                     && ((fcnt_reg - {1'b0, pop} + {1'b0, infl_reg}) < 2'h2);
    infl_next      = rd_go;
    infl_last_next = (rd_ptr_reg == rd_len_reg - 11'h001);
    fifo_next[0]   = fifo_reg[0];
    fifo_next[1]   = fifo_reg[1];
    fwp_next       = fwp_reg;
    frp_next       = frp_reg;
    fcnt_next      = fcnt_reg;
    if (infl_reg)
    begin
      fifo_next[fwp_reg] = '{data: ram_rdata, last: infl_last_reg};
      fwp_next           = !fwp_reg;
    end
    if (pop)
      frp_next = !frp_reg;
    fcnt_next = fcnt_reg + {1'b0, infl_reg} - {1'b0, pop};
  end

  // inactivity watch and modem lines
  always_comb
  begin
    moved          = acc || pop;
    inact_hit      = net_up && (inact_reg != 16'h0000)
                     && (inact_cnt_reg >= inact_reg) && tick;
    inact_cnt_next = inact_cnt_reg;
    if (moved || inact_hit || !net_up)
      inact_cnt_next = 16'h0000;
    else if (tick)
      inact_cnt_next = sat_inc(inact_cnt_reg);
    close_next = inact_hit;
    rts_next   = ctrl_reg[`SRP_CTRL_RTS];
    dtr_next   = ctrl_reg[`SRP_CTRL_DTR];
    if (!net_up && !ctrl_reg[`SRP_CTRL_DSEL])
      rts_next = ctrl_reg[`SRP_CTRL_DHIGH];
    if (!net_up && ctrl_reg[`SRP_CTRL_DSEL])
      dtr_next = ctrl_reg[`SRP_CTRL_DHIGH];
  end

  // state registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      ctrl_reg      <= `SRP_CTRL_RST;
      delim_reg     <= `SRP_DELIM_RST;
      plen_reg      <= `SRP_PLEN_RST;
      flush_reg     <= `SRP_FLUSH_RST;
      inact_reg     <= `SRP_INACT_RST;
      rdata_reg     <= 32'h0000_0000;
      sync1_reg     <= 1'b0;
      sync2_reg     <= 1'b0;
      tick_reg      <= 32'h0000_0000;
      state_reg     <= ST_FILL;
      wcnt_reg      <= 11'h000;
      rd_len_reg    <= 11'h000;
      rd_ptr_reg    <= 11'h000;
      prev_d1_reg   <= 1'b0;
      extra_reg     <= 2'h0;
      idle_reg      <= 16'h0000;
      inact_cnt_reg <= 16'h0000;
      pkts_reg      <= 16'h0000;
      close_reg     <= 1'b0;
      rts_reg       <= 1'b0;
      dtr_reg       <= 1'b0;
      infl_reg      <= 1'b0;
      infl_last_reg <= 1'b0;
      fifo_reg[0]   <= '0;
      fifo_reg[1]   <= '0;
      fwp_reg       <= 1'b0;
      frp_reg       <= 1'b0;
      fcnt_reg      <= 2'h0;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      delim_reg     <= delim_next;
      plen_reg      <= plen_next;
      flush_reg     <= flush_next;
      inact_reg     <= inact_next;
      rdata_reg     <= rdata_next;
      sync1_reg     <= i_net_up;
      sync2_reg     <= sync1_reg;
      tick_reg      <= tick_next;
      state_reg     <= state_next;
      wcnt_reg      <= wcnt_next;
      rd_len_reg    <= rd_len_next;
      rd_ptr_reg    <= rd_ptr_next;
      prev_d1_reg   <= prev_d1_next;
      extra_reg     <= extra_next;
      idle_reg      <= idle_next;
      inact_cnt_reg <= inact_cnt_next;
      pkts_reg      <= pkts_next;
      close_reg     <= close_next;
      rts_reg       <= rts_next;
      dtr_reg       <= dtr_next;
      infl_reg      <= infl_next;
      infl_last_reg <= infl_last_next;
      fifo_reg[0]   <= fifo_next[0];
      fifo_reg[1]   <= fifo_next[1];
      fwp_reg       <= fwp_next;
      frp_reg       <= frp_next;
      fcnt_reg      <= fcnt_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_net_close = close_reg;
  assign o_rts       = rts_reg;
  assign o_dtr       = dtr_reg;

  srp_byte_ram u_ram (
    .i_core_clk (i_core_clk),
    .i_wr       (acc),
    .i_waddr    (wcnt_reg[9:0]),
    .i_wdata    (i_rx_data),
    .i_rd       (rd_go),
    .i_raddr    (rd_ptr_reg[9:0]),
    .o_rdata    (ram_rdata)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_rts_on_down: assert property (!net_up && !ctrl_reg[`SRP_CTRL_DSEL]
    |=> o_rts == $past(ctrl_reg[`SRP_CTRL_DHIGH])) else $error("rts level");
  a_len_zero_grow: assert property (acc && plen_reg == 11'h000
    && !full_hit && !match && extra_reg == 2'h0
    |=> wcnt_reg == $past(newcnt)) else $error("zero limit closed");
  a_len_limit_hit: assert property (len_hit
    |=> wcnt_reg == 11'h000 ##0 state_reg == ST_DRAIN
    ##0 rd_len_reg == $past(plen_reg) - ($past(term_hit)
    && $past(mode) == TM_STRIP ? $past(tlen) : 11'h000))
    else $error("length close");
  a_pair_order: assert property (acc && ctrl_reg[`SRP_CTRL_D1EN]
    && ctrl_reg[`SRP_CTRL_D2EN] && !prev_d1_reg |-> !match)
    else $error("second delimiter alone");
  a_full_close: assert property (full_hit
    |=> state_reg == ST_DRAIN && wcnt_reg == 11'h000) else $error("full");
  a_mode_ignored: assert property (acc && !ctrl_reg[`SRP_CTRL_D1EN]
    |-> !match) else $error("match with delimiter off");
  a_pass_keep: assert property (term_hit && mode == TM_PASS
    |=> state_reg == ST_DRAIN && rd_len_reg == $past(newcnt))
    else $error("pass length");
  a_plus_wait: assert property (term_hit && mode == TM_PLUS2
    && !len_hit && !full_hit |=> extra_reg == 2'h2 && state_reg == ST_FILL)
    else $error("plus two wait");
  a_strip_drop: assert property (term_hit && mode == TM_STRIP
    && newcnt > tlen |=> rd_len_reg == $past(newcnt) - $past(tlen))
    else $error("strip length");
  a_idle_off: assert property (flush_reg == 16'h0000 |-> !idle_hit)
    else $error("idle close while off");
  a_idle_close: assert property (idle_hit
    |=> wcnt_reg == 11'h000 && rd_len_reg == $past(wcnt_reg))
    else $error("idle close");
  a_net_close: assert property (inact_hit |=> o_net_close
    ##1 !o_net_close) else $error("inactivity close");
  a_one_packet: assert property (close && close_len != 11'h000
    |=> pkts_reg == $past(pkts_reg) + 16'h0001 && extra_reg == 2'h0
    && idle_reg == 16'h0000) else $error("close count");
  a_idle_empty: assert property (wcnt_reg == 11'h000
    |-> idle_reg == 16'h0000) else $error("idle runs empty");
endmodule : srp_rx_packetizer

//--- verification/srp_net_sink.sv
// srp_net_sink: network side model, takes beats and counts packets
// assumes the core clock; i_slow stalls every other cycle
`timescale 1ns/1ps
module srp_net_sink (
  input  wire logic               i_core_clk, // core clock
  input  wire logic               i_srst,     // sync reset
  input  wire logic               i_slow,     // stall every other cycle
  input  wire logic               i_tx_valid, // beat offered
  input  wire srp_pkg::srp_beat_s i_tx_beat,  // byte and last flag
  output logic                    o_tx_ready  // beat taken when high
);
  import srp_pkg::*;
  logic [7:0] got[$];
  int         pkts;
  // toggling ready forces the buffer to hold a stalled beat
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_tx_ready <= 1'b0;
      pkts       <= 0;
    end
    else
    begin
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready && i_tx_beat.last)
        pkts <= pkts + 1;
    end
  end

  // the bench empties the queue between cases, so it stays out of always_ff
  always @(posedge i_core_clk)
  begin
    if (!i_srst && i_tx_valid && o_tx_ready)
    begin
      got.push_back(i_tx_beat.data);
    end
  end
endmodule : srp_net_sink

//--- verification/srp_rx_packetizer_tb_top.sv
// srp_rx_packetizer_tb_top: self-checking bench for the packetizer
// assumes TICK_CYC of 10, so one ms tick is ten core cycles
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_rx_packetizer_tb_top;
  import srp_pkg::*;
  typedef struct {
    logic [7:0]  ctrl;
    logic [15:0] delim;
    logic [10:0] plen;
    int          n_in;
    logic [31:0] din;
    int          n_out;
    logic [31:0] dout;
  } srp_row_s;
  logic        clk, srst, reg_wr, reg_rd, rx_valid, rx_ready, tx_valid;
  logic        tx_ready, net_up, net_close, rts, dtr, slow;
  logic [7:0]  reg_addr, rx_data;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  srp_beat_s   tx_beat;
  int          error_cnt, checks_done;
  srp_row_s    rows[9];

  srp_rx_packetizer #(.TICK_CYC(10)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_beat(tx_beat),
    .i_tx_ready(tx_ready), .i_net_up(net_up), .o_net_close(net_close),
    .o_rts(rts), .o_dtr(dtr));
  srp_net_sink sink (
    .i_core_clk(clk), .i_srst(srst), .i_slow(slow), .i_tx_valid(tx_valid),
    .i_tx_beat(tx_beat), .o_tx_ready(tx_ready));

  // 10 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  // a hang ends the run at once
  task automatic fail(input string msg);
    check(1'b0, msg);
    final_report();
  endtask : fail

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // ready is sampled at the falling edge so the taking edge is known
  task automatic send(input logic [7:0] b);
    int k;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    for (k = 0; k < 5000; k++)
    begin
      @(negedge clk);
      if (rx_ready === 1'b1)
        break;
    end
    if (k == 5000)
      fail("byte never taken");
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask : send

  task automatic wait_pkt(input int n);
    int k;
    for (k = 0; k < 5000 && sink.pkts < n; k++)
      @(posedge clk);
    if (sink.pkts < n)
      fail("packet missing");
  endtask : wait_pkt

  // main sequence
  initial
  begin
    int i, j, k;
    logic ok;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    net_up = 1'b1;
    slow = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    rows[0] = '{8'h13, 16'h000D, 11'h0, 3, 32'h41420D00, 3, 32'h41420D00};
    rows[1] = '{8'h53, 16'h000D, 11'h0, 3, 32'h410D4300, 3, 32'h410D4300};
    rows[2] = '{8'h93, 16'h000D, 11'h0, 4, 32'h410D4344, 4, 32'h410D4344};
    rows[3] = '{8'hD3, 16'h000D, 11'h0, 3, 32'h41420D00, 2, 32'h41420000};
    rows[4] = '{8'h33, 16'h0A0D, 11'h0, 4, 32'h0D410D0A, 4, 32'h0D410D0A};
    rows[5] = '{8'hF3, 16'h0A0D, 11'h0, 3, 32'h410D0A00, 1, 32'h41000000};
    rows[6] = '{8'h03, 16'h0000, 11'h3, 3, 32'h41424300, 3, 32'h41424300};
    rows[7] = '{8'hC3, 16'h000D, 11'h2, 2, 32'h0D410000, 2, 32'h0D410000};
    rows[8] = '{8'h53, 16'h000D, 11'h2, 2, 32'h410D0000, 2, 32'h410D0000};
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(negedge clk);
    check(rx_ready === 1'b1 && tx_valid === 1'b0, "idle after reset");
    check(net_close === 1'b0 && rts === 1'b1 && dtr === 1'b1, "modem up");
    rd(`SRP_ADDR_CTRL, rdv);
    check(rdv === 32'h3, "ctrl reset value");
    rd(8'h18, rdv);
    check(rdv === 32'h0, "unmapped read");
    wr(`SRP_ADDR_PLEN, 32'h7D0);
    rd(`SRP_ADDR_PLEN, rdv);
    check(rdv === 32'h400, "length clip");
    // one row per closing case, odd rows with a stalling sink
    for (i = 0; i < 9; i++)
    begin
      wr(`SRP_ADDR_PLEN, {21'h0, rows[i].plen});
      wr(`SRP_ADDR_DELIM, {16'h0, rows[i].delim});
      wr(`SRP_ADDR_CTRL, {24'h0, rows[i].ctrl});
      slow <= i[0];
      for (j = 0; j < rows[i].n_in; j++)
        send(rows[i].din[31-8*j -: 8]);
      wait_pkt(i + 1);
      ok = (sink.got.size() == rows[i].n_out);
      for (j = 0; j < rows[i].n_out; j++)
        ok = ok && (sink.got[j] === rows[i].dout[31-8*j -: 8]);
      check(ok, "packet bytes");
      sink.got.delete();
    end
    repeat (10) @(posedge clk);
    check(sink.pkts === 9, "one packet per close");
    rd(`SRP_ADDR_STAT, rdv);
    check(rdv[31:16] === 16'd9, "closed count");
    // no close cause at all: the byte must wait
    wr(`SRP_ADDR_PLEN, 32'h0);
    wr(`SRP_ADDR_CTRL, 32'h3);
    send(8'h61);
    repeat (100) @(posedge clk);
    check(sink.pkts === 9, "held without cause");
    wr(`SRP_ADDR_FLUSH, 32'h2);
    wait_pkt(10);
    check(sink.got.size() == 1, "idle flush bytes");
    sink.got.delete();
    send(8'h41);
    repeat (15) @(posedge clk);
    send(8'h42);
    repeat (15) @(posedge clk);
    check(sink.pkts === 10, "idle timer restart");
    wait_pkt(11);
    check(sink.got.size() == 2, "idle flush pair");
    sink.got.delete();
    // full buffer with a delimiter that never comes
    wr(`SRP_ADDR_FLUSH, 32'h0);
    wr(`SRP_ADDR_DELIM, 32'h0D);
    wr(`SRP_ADDR_CTRL, 32'h13);
    slow <= 1'b1;
    for (j = 0; j < 1024; j++)
    begin
      if (j == 1023)
        check(sink.pkts === 11, "no early close");
      send(8'h55);
    end
    wait_pkt(12);
    check(sink.got.size() == 1024, "full buffer packet");
    // link loss with rts low, then dtr high and dtr low
    net_up <= 1'b0;
    repeat (5) @(negedge clk);
    check(rts === 1'b0 && dtr === 1'b1, "rts low on loss");
    // dtr level bit off, so only the loss override can make it high
    wr(`SRP_ADDR_CTRL, 32'h0D);
    repeat (3) @(negedge clk);
    check(rts === 1'b1 && dtr === 1'b1, "dtr stays high");
    wr(`SRP_ADDR_CTRL, 32'h07);
    repeat (3) @(negedge clk);
    check(rts === 1'b1 && dtr === 1'b0, "dtr low on loss");
    net_up <= 1'b1;
    repeat (5) @(posedge clk);
    // inactivity close after 3 ms of silence
    // a moved byte restarts the count at a known edge
    wr(`SRP_ADDR_INACT, 32'h3);
    send(8'h41);
    for (k = 0; k < 100 && net_close !== 1'b1; k++)
      @(negedge clk);
    // 3 ms is 30 cycles; the ms tick adds up to one ms of slack
    check(net_close === 1'b1 && k >= 31 && k <= 41,
          "inactivity close");
    wr(`SRP_ADDR_INACT, 32'h0);
    final_report();
  end
endmodule : srp_rx_packetizer_tb_top
